// ---- hdl/region_string_injector.sv ----
// region string injector: sequencer, bit framer and character fifo
`timescale 1ns/10ps

module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // write side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // read side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_type;
  fifo_type s_q, s_d;
  logic full, empty;

  // full and empty from wrap-extended pointers
  assign empty = s_q.wr == s_q.rd;
  assign full = (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]) && (s_q.wr[AW] != s_q.rd[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = s_q.mem[s_q.rd[AW-1:0]];

  // pointer and storage update
  always_comb begin
    s_d = s_q;
    if (in_valid && !full) begin
      s_d.mem[s_q.wr[AW-1:0]] = in_data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      s_d.rd = s_q.rd + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

module region_string_injector
  import injector_pkg::*;
#(
  parameter int unsigned FLOAT_CYCLES = CYC_FLOAT,
  parameter int unsigned DATA_CYCLES = CYC_DATA,
  parameter int unsigned GATE_CYCLES = CYC_GATE,
  parameter int unsigned BIT_CYCLES = CYC_BIT,
  parameter logic [1:0] REGION = injector_pkg::REGION_EUROPE,
  parameter bit MULTI_REGION = 1'b0,
  parameter bit STEALTH = 1'b0,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // lid sense pin, high while lid open
  input wire logic lid_open,
  // open-drain gate pin
  input wire logic gate_in,
  output logic gate_out,
  output logic gate_oe,
  // open-drain data pin
  input wire logic data_in,
  output logic data_out,
  output logic data_oe,
  // status
  output logic sending
);
  import injector_pkg::*;

  typedef struct packed {
    phase_type phase;
    logic [23:0] tmr;
    logic [4:0] bitn;
    logic [10:0] frame;
    logic [1:0] region;
    logic [1:0] load_idx;
    logic [1:0] sent;
    logic data_pull;
    logic gate_pull;
    logic lid_s1;
    logic lid_s2;
    logic lid_p;
    logic armed;
    logic busy;
  } state_type;
  state_type s_q, s_d;

  logic [7:0] f_in, f_out;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;

  // character at a string position for a given region
  function automatic logic [7:0] string_char(input logic [1:0] idx, input logic [1:0] reg_sel);
    logic [7:0] c;
    c = CHAR0;
    unique case (idx)
      2'h0: c = CHAR0;
      2'h1: c = CHAR1;
      2'h2: c = CHAR2;
      2'h3: c = (reg_sel == REGION_AMERICA) ? CHAR_AM :
                (reg_sel == REGION_JAPAN) ? CHAR_JP : CHAR_EU;
    endcase
    return c;
  endfunction

  // characters are queued ahead; the framer pops one per 44 ms
  assign f_in = string_char(s_q.load_idx, s_q.region);
  assign f_in_valid = s_q.busy;
  assign f_out_ready = (s_q.phase == ST_CHAR) && (s_q.tmr == 24'h0)
                       && (s_q.bitn == 5'h0) && f_out_valid;

  char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_data(f_in),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .out_data(f_out),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready)
  );

  // pins only ever pull low; output value is constant zero
  assign data_out = 1'b0;
  assign gate_out = 1'b0;
  assign data_oe = s_q.data_pull;
  assign gate_oe = s_q.gate_pull;
  assign sending = s_q.busy;

  // sequencer: one prescaler counter times every interval
  always_comb begin
    s_d = s_q;
    s_d.lid_s1 = lid_open;
    s_d.lid_s2 = s_q.lid_s1;
    s_d.lid_p = s_q.lid_s2;
    // lid opening re-arms the stealth variant; set wins over use
    if (s_q.lid_s2 && !s_q.lid_p) begin
      s_d.armed = 1'b1;
    end
    // producer feeds four characters per loop into the fifo
    if (s_q.busy && f_in_ready) begin
      s_d.load_idx = s_q.load_idx + 2'h1;
      if (s_q.load_idx == 2'h3) begin
        s_d.busy = 1'b0;
      end
    end
    if (s_q.tmr != 24'h0) begin
      s_d.tmr = s_q.tmr - 24'h1;
    end
    unique case (s_q.phase)
      ST_FLOAT: begin
        s_d.data_pull = 1'b0;
        s_d.gate_pull = 1'b0;
        if (s_q.tmr == 24'h0) begin
          s_d.phase = ST_DATA_LOW;
          s_d.data_pull = 1'b1;
          s_d.tmr = 24'(DATA_CYCLES - 1);
        end
      end
      ST_DATA_LOW: begin
        if (s_q.tmr == 24'h0) begin
          s_d.phase = ST_GATE_LOW;
          s_d.gate_pull = 1'b1;
          s_d.tmr = 24'(GATE_CYCLES - 1);
        end
      end
      ST_GATE_LOW, ST_QUIET: begin
        if (s_q.tmr == 24'h0 && (s_q.phase == ST_GATE_LOW || s_q.armed)) begin
          // start a loop: idle is eighteen one bits, line held low
          s_d.phase = ST_IDLE;
          s_d.data_pull = 1'b1;
          s_d.gate_pull = 1'b1;
          // one cycle is spent in the idle-to-char handover, so load two short
          s_d.tmr = 24'(IDLE_BITS * BIT_CYCLES - 2);
          s_d.busy = 1'b1;
          s_d.load_idx = 2'h0;
          s_d.sent = 2'h0;
          s_d.armed = 1'b0;
          if (s_q.lid_s2 && !s_q.lid_p) begin
            s_d.armed = 1'b1;
          end
        end else if (s_q.tmr == 24'h0) begin
          // quiet: last stop bit has run its full length, now float both wires
          s_d.data_pull = 1'b0;
          s_d.gate_pull = 1'b0;
        end
      end
      ST_IDLE: begin
        if (s_q.tmr == 24'h0) begin
          s_d.phase = ST_CHAR;
          s_d.bitn = 5'h0;
        end
      end
      ST_CHAR: begin
        if (s_q.tmr == 24'h0) begin
          if (s_q.bitn == 5'h0) begin
            if (f_out_valid) begin
              // frame: start 0, data lsb first, two stop ones
              s_d.frame = {2'b11, f_out, 1'b0};
              s_d.data_pull = 1'b0;
              s_d.bitn = 5'(CHAR_BITS - 1);
              s_d.tmr = 24'(BIT_CYCLES - 1);
            end
          end else begin
            s_d.frame = {1'b0, s_q.frame[10:1]};
            s_d.data_pull = s_q.frame[1];
            s_d.bitn = s_q.bitn - 5'h1;
            s_d.tmr = 24'(BIT_CYCLES - 1);
            if (s_q.bitn == 5'h1) begin
              // second stop bit runs a full period, then next character or loop
              s_d.data_pull = 1'b1;
              s_d.bitn = 5'h0;
              s_d.sent = s_q.sent + 2'h1;
              if (s_q.sent == 2'(NUM_CHARS - 1)) begin
                if (MULTI_REGION) begin
                  s_d.region = (s_q.region == REGION_JAPAN) ? REGION_AMERICA
                               : s_q.region + 2'h1;
                end
                if (STEALTH && !s_q.armed) begin
                  // pins are released only once the stop bit has finished
                  s_d.phase = ST_QUIET;
                end else begin
                  s_d.phase = ST_GATE_LOW;
                end
              end
            end
          end
        end
      end
    endcase
  end

  // reset reloads the power-up float wait and the REGION selector; everything else clears
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.phase <= ST_FLOAT;
      s_q.tmr <= 24'(FLOAT_CYCLES - 1);
      s_q.region <= REGION;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ---- pkg/injector_pkg.sv ----
// constants and types shared by the region string injector
package injector_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  // times in microseconds as specified
  localparam int unsigned T_FLOAT_US = 50000;
  localparam int unsigned T_DATA_US = 850000;
  localparam int unsigned T_GATE_US = 314000;
  localparam int unsigned T_BIT_US = 4000;
  localparam int unsigned IDLE_BITS = 18;
  localparam int unsigned CHAR_BITS = 11;
  localparam int unsigned NUM_CHARS = 4;
  // cycle counts derived from the clock rate (exact multiples here)
  localparam int unsigned CYC_FLOAT = T_FLOAT_US * (CLK_HZ / 1000000);
  localparam int unsigned CYC_DATA = T_DATA_US * (CLK_HZ / 1000000);
  localparam int unsigned CYC_GATE = T_GATE_US * (CLK_HZ / 1000000);
  localparam int unsigned CYC_BIT = T_BIT_US * (CLK_HZ / 1000000);
  // region selector codes
  localparam logic [1:0] REGION_AMERICA = 2'h0;
  localparam logic [1:0] REGION_EUROPE = 2'h1;
  localparam logic [1:0] REGION_JAPAN = 2'h2;
  // arbitrary neutral string, not any real identity value
  localparam logic [7:0] CHAR0 = 8'h51;
  localparam logic [7:0] CHAR1 = 8'h52;
  localparam logic [7:0] CHAR2 = 8'h53;
  localparam logic [7:0] CHAR_AM = 8'h41;
  localparam logic [7:0] CHAR_EU = 8'h42;
  localparam logic [7:0] CHAR_JP = 8'h43;
  typedef enum logic [2:0] {
    ST_FLOAT, ST_DATA_LOW, ST_GATE_LOW, ST_IDLE, ST_CHAR, ST_QUIET
  } phase_type;
endpackage

// ---- test/injector_chk_props.sv ----
// pin checker for the region string injector
`timescale 1ns/10ps
module injector_chk #(
  parameter int unsigned FLOAT_CYCLES = 50,
  parameter int unsigned DATA_CYCLES = 80,
  parameter int unsigned GATE_CYCLES = 30,
  parameter int unsigned BIT_CYCLES = 10
) (
  // watched pins
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic gate_out,
  input wire logic gate_oe,
  input wire logic data_out,
  input wire logic data_oe,
  input wire logic sending
);
  localparam int unsigned T_FIRST = FLOAT_CYCLES + DATA_CYCLES + GATE_CYCLES + 18 * BIT_CYCLES;
  logic [31:0] cnt_q;
  logic [31:0] run_q;
  logic seen_q;
  // cycle count since release; 32 bits outlast any run
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      run_q <= '0;
      seen_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      run_q <= data_oe ? run_q + 32'h1 : 32'h0;
      seen_q <= seen_q | (!data_oe && run_q != 0);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence held_low;
    !data_oe [*8];
  endsequence
  pins_low_a: assert property (!data_out && !gate_out)
    else $error("pin driven high");
  float_first_a: assert property (cnt_q < FLOAT_CYCLES |-> !data_oe && !gate_oe)
    else $error("early pull");
  data_pull_a: assert property ($rose(data_oe) && !gate_oe |-> cnt_q == FLOAT_CYCLES)
    else $error("data pull time");
  gate_wait_a: assert property (cnt_q < FLOAT_CYCLES + DATA_CYCLES |-> !gate_oe)
    else $error("early gate");
  gate_pull_a: assert property ($rose(gate_oe) |-> cnt_q == FLOAT_CYCLES + DATA_CYCLES)
    else $error("gate pull time");
  gate_hold_a: assert property (gate_oe |=> gate_oe)
    else $error("gate released");
  first_idle_a: assert property ($fell(data_oe) && !seen_q |-> cnt_q == T_FIRST)
    else $error("first idle length");
  start_bit_a: assert property ($fell(data_oe) |=> held_low)
    else $error("short low bit");
  one_run_a: assert property ($fell(data_oe) && seen_q |-> run_q >= BIT_CYCLES &&
    run_q <= 20 * BIT_CYCLES + 2) else $error("bad pull run");
  send_gate_a: assert property (sending |-> gate_oe)
    else $error("sending early");
endmodule
bind region_string_injector injector_chk #(.FLOAT_CYCLES(FLOAT_CYCLES),
  .DATA_CYCLES(DATA_CYCLES), .GATE_CYCLES(GATE_CYCLES), .BIT_CYCLES(BIT_CYCLES)) chk (
  .ref_clk(ref_clk), .resetn(resetn), .gate_out(gate_out), .gate_oe(gate_oe),
  .data_out(data_out), .data_oe(data_oe), .sending(sending));

// ---- test/board_model.sv ----
// mainboard side: pulled-up wires and gate inversion
`timescale 1ns/10ps
module board_model (
  // injector pins
  input wire logic gate_oe,
  input wire logic gate_out,
  input wire logic data_oe,
  input wire logic data_out,
  // wire levels
  output logic gate_pin,
  output logic data_pin,
  output logic board_data
);
  // pull-ups own the wire whenever the injector lets go
  assign gate_pin = gate_oe ? gate_out : 1'b1;
  assign data_pin = data_oe ? data_out : 1'b1;
  // older boards drive their data line as inverse of gate
  assign board_data = ~gate_pin;
  // sync test clock is not modelled: the injector free-runs unaligned
  // string acceptance latches on the board until the lid reopens
endmodule

// ---- test/tb.sv ----
// self-checking bench for the region string injector
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module tb;
  import injector_pkg::*;
  localparam int BIT = 10;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic lid_open = 1'b0;
  logic gate_out, gate_oe, data_out, data_oe, sending, gate_pin, data_pin;
  int fail_count = 0;
  int samples_checked = 0;
  int k;
  logic [7:0] ch;
  logic [1:0] st;
  // two whole loops of the default string
  logic [7:0] rows [8] = '{CHAR0, CHAR1, CHAR2, CHAR_EU, CHAR0, CHAR1, CHAR2, CHAR_EU};
  always #50 ref_clk = ~ref_clk;
  region_string_injector #(.FLOAT_CYCLES(50), .DATA_CYCLES(80), .GATE_CYCLES(30),
    .BIT_CYCLES(BIT)) dut (.ref_clk(ref_clk), .resetn(resetn), .lid_open(lid_open),
    .gate_in(gate_pin), .gate_out(gate_out), .gate_oe(gate_oe), .data_in(data_pin),
    .data_out(data_out), .data_oe(data_oe), .sending(sending));
  board_model board (.gate_oe(gate_oe), .gate_out(gate_out), .data_oe(data_oe),
    .data_out(data_out), .gate_pin(gate_pin), .data_pin(data_pin), .board_data());
  task automatic end_of_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // counts falling edges until the enable shows v; a hang ends the run
  task automatic wait_for(input bit gate, input logic v, output int cnt);
    cnt = 0;
    while ((gate ? gate_oe : data_oe) !== v) begin
      @(negedge ref_clk);
      cnt++;
      if (cnt > 2000) begin
        fail_count++;
        $display("Error %0t: wait ran out", $time);
        end_of_test();
      end
    end
  endtask
  // mid-bit sampling; each start edge resynchronises past the char gap
  task automatic get_char(output logic [7:0] c, output logic [1:0] s);
    int n;
    wait_for(1'b0, 1'b0, n);
    repeat (BIT / 2) @(negedge ref_clk);
    `CHK(data_pin, 1'b1)
    for (int i = 0; i < 10; i++) begin
      repeat (BIT) @(negedge ref_clk);
      if (i < 8) c[i] = ~data_pin;
      else s[i - 8] = ~data_pin;
    end
  endtask
  // reset for four cycles, then time each power-up step
  task automatic power_up();
    int n;
    resetn = 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK({data_oe, gate_oe}, 2'h0)
    resetn = 1'b1;
    wait_for(1'b0, 1'b1, n);
    `CHK(n, 50)
    wait_for(1'b1, 1'b1, n);
    `CHK(n, 80)
    wait_for(1'b0, 1'b0, n);
    `CHK(n, 30 + 18 * BIT)
  endtask
  initial begin
    power_up();
    foreach (rows[r]) begin
      get_char(ch, st);
      `CHK(ch, rows[r])
      `CHK({st, gate_oe}, 3'h7)
    end
    // reset in mid-character must restart from the floating phase
    wait_for(1'b0, 1'b0, k);
    repeat (3 * BIT) @(negedge ref_clk);
    power_up();
    lid_open = 1'b1;
    get_char(ch, st);
    lid_open = 1'b0;
    `CHK(ch, CHAR0)
    end_of_test();
  end
endmodule
